// [pkg/fsg_pkg.sv]
// shared constants, opcodes and types for the flash status and write gate
package fsg_pkg;

  // status byte field positions
  localparam int STS_BUSY    = 0;
  localparam int STS_WEL     = 1;
  localparam int STS_BP_LSB  = 2;
  localparam int STS_BP_MSB  = 5;
  localparam int STS_QE      = 6;
  localparam int STS_LOCK    = 7;
  localparam int NV_WIDTH    = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] NV_RESET     = 6'h00;

  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG_A   = 8'h32;
  localparam logic [7:0] OP_QUAD_PROG_B   = 8'h38;
  localparam logic [7:0] OP_SECT_ERASE_A  = 8'hD7;
  localparam logic [7:0] OP_SECT_ERASE_B  = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE    = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;
  localparam logic [7:0] OP_FUNC_WRITE    = 8'h42;
  localparam logic [7:0] OP_INFO_ERASE    = 8'h64;
  localparam logic [7:0] OP_INFO_PROG     = 8'h62;

  // frame lengths in serial bits
  localparam logic [5:0] BITS_OPCODE = 6'd8;
  localparam logic [5:0] BITS_REGW   = 6'd16;
  localparam logic [5:0] BITS_ADDR   = 6'd32;
  localparam logic [5:0] BITS_PROG   = 6'd40;
  localparam logic [5:0] BITS_MAX    = 6'd63;

  // address map of the 64 KB blocks
  localparam int BLK_LSB    = 16;
  localparam int BLK_MSB    = 22;
  localparam int NUM_BLOCKS = 128;

  // internal write cycle time
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WRITE_CYCLE_NS = 2000;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } fsg_state_t;

endpackage : fsg_pkg

// [core/fsg_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module fsg_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst,     // sync reset, active high
  input  wire logic pin_in,  // asynchronous pin level
  output logic      lvl_out  // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lvl_out <= RST_VAL;
    end else if (s2_r == s3_r) begin
      lvl_out <= s3_r;
    end
  end
endmodule : fsg_sync

// [core/fsg_timer.sv]
// internal write cycle timer, one-cycle done pulse at the end
`timescale 1ns/10ps
module fsg_timer #(
  parameter int CYCLES = 200
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst,     // sync reset, active high
  input  wire logic start,   // load and run
  output logic      done     // pulse when the cycle ends
);
  logic [31:0] cnt_r;

  if (CYCLES < 1) begin : g_chk
    $error("fsg_timer: CYCLES must be at least one");
  end

  // count down from load; start is never raised while running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 32'h0000_0000;
      done  <= 1'b0;
    end else if (start) begin
      cnt_r <= 32'(CYCLES);
      done  <= 1'b0;
    end else begin
      done  <= (cnt_r == 32'h0000_0001);
      if (cnt_r != 32'h0000_0000) begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end
endmodule : fsg_timer

// [core/fsg_gate.sv]
// serial flash status byte, write-enable latch and write gating
// Behaviour
// - busy flag in status bit 0, one during an internal cycle, zero idle
// - busy flag is read-only; status writes never change it
// - status write, program and erase are accepted only while not busy
// - write-enable latch in bit 1; zero inhibits gated operations
// - write-enable command sets the latch
// - write-disable command clears the latch
// - latch clears automatically when an internal cycle finishes
// - status-write data never alters the latch
// - page program and quad page program need the latch set
// - sector, half-block and block erase need the latch set
// - chip erase, status, function write, info row erase/program need the latch
// - protection, quad and lock bits kept and changed only by status write
// - all eight status bits are zero after reset
// - status-read command returns the whole status byte
// - bits two to five form the block protection level
// - bit six enables the quad data pins
// - bit seven is the status lock, working with the protect pin
// - lock set and protect pin low makes status write ignored
// - program or erase to a protected area is inhibited
// - status byte repeats on the output while chip select stays low
`timescale 1ns/10ps
module fsg_gate
  import fsg_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLE_CYC
) (
  input  wire logic        clk_sys,       // system clock, 100 MHz
  input  wire logic        rst,           // sync reset, active high
  input  wire logic        sck_in,        // serial clock pin
  input  wire logic        cs_n_in,       // chip select pin, active low
  input  wire logic        si_in,         // serial data in pin
  input  wire logic        wp_n_in,       // write protect pin, active low
  output logic             so_o,          // serial data out
  output logic             so_oe_o,       // serial out enable
  output logic [7:0]       status_o,      // status byte copy
  output logic             quad_en_o,     // quad pins enabled
  output logic [3:0]       prot_level_o,  // block protection level
  output logic             op_start_o,    // internal cycle start pulse
  output logic [7:0]       op_code_o,     // opcode of running cycle
  output logic [23:0]      op_addr_o,     // address of running cycle
  output logic             op_done_o,     // internal cycle end pulse
  output logic             cmd_reject_o   // pulse for a gated command dropped by a clear latch
);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic wp_n_s;

  fsg_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (sck_in),
    .lvl_out (sck_s)
  );
  fsg_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (cs_n_in),
    .lvl_out (cs_n_s)
  );
  fsg_sync #(.RST_VAL(1'b0)) u_sync_si (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (si_in),
    .lvl_out (si_s)
  );
  fsg_sync #(.RST_VAL(1'b1)) u_sync_wp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (wp_n_in),
    .lvl_out (wp_n_s)
  );

  //////////////////////////////////////////////////////////////////////
  // edge detection on the filtered levels
  logic sck_q_r;
  logic cs_q_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_q_r <= 1'b0;
      cs_q_r  <= 1'b1;
    end else begin
      sck_q_r <= sck_s;
      cs_q_r  <= cs_n_s;
    end
  end

  // clock edges count only inside a frame
  assign sck_rise = sck_s & ~sck_q_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_q_r & ~cs_n_s;
  assign cs_rise  = cs_n_s & ~cs_q_r;

  //////////////////////////////////////////////////////////////////////
  // serial receive: bit count, opcode, data and address
  logic [5:0]  bit_cnt_r;
  logic [31:0] shift_r;
  logic [7:0]  opcode_r;
  logic [7:0]  wdata_r;
  logic [23:0] addr_r;

  // counter saturates so long program frames stay recognisable
  always_ff @(posedge clk_sys) begin
    if (rst || cs_q_r) begin
      bit_cnt_r <= 6'd0;
    end else if (sck_rise && bit_cnt_r != BITS_MAX) begin
      bit_cnt_r <= bit_cnt_r + 6'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_r <= 32'h0000_0000;
    end else if (sck_rise) begin
      shift_r <= {shift_r[30:0], si_s};
    end
  end

  // capture fields at the bit that completes them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opcode_r <= 8'h00;
      wdata_r  <= 8'h00;
      addr_r   <= 24'h00_0000;
    end else if (sck_rise) begin
      if (bit_cnt_r == BITS_OPCODE - 6'd1) begin
        opcode_r <= {shift_r[6:0], si_s};
      end
      if (bit_cnt_r == BITS_REGW - 6'd1) begin
        wdata_r <= {shift_r[6:0], si_s};
      end
      if (bit_cnt_r == BITS_ADDR - 6'd1) begin
        addr_r <= {shift_r[22:0], si_s};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // instruction classification
  logic is_prog;
  logic is_erase;
  logic is_chip;
  logic is_regw;
  logic is_info;
  logic is_gated;
  logic len_ok;

  assign is_prog  = (opcode_r == OP_PAGE_PROG) || (opcode_r == OP_QUAD_PROG_A) ||
                    (opcode_r == OP_QUAD_PROG_B);
  assign is_erase = (opcode_r == OP_SECT_ERASE_A) || (opcode_r == OP_SECT_ERASE_B) ||
                    (opcode_r == OP_HALF_ERASE) || (opcode_r == OP_BLOCK_ERASE);
  assign is_chip  = (opcode_r == OP_CHIP_ERASE_A) || (opcode_r == OP_CHIP_ERASE_B);
  assign is_regw  = (opcode_r == OP_STATUS_WRITE) || (opcode_r == OP_FUNC_WRITE);
  assign is_info  = (opcode_r == OP_INFO_ERASE) || (opcode_r == OP_INFO_PROG);
  assign is_gated = is_prog | is_erase | is_chip | is_regw | is_info;

  // frame must carry all fields of the instruction
  always_comb begin
    len_ok = 1'b0;
    if (is_prog || opcode_r == OP_INFO_PROG) begin
      len_ok = (bit_cnt_r >= BITS_PROG);
    end else if (is_erase || opcode_r == OP_INFO_ERASE) begin
      len_ok = (bit_cnt_r == BITS_ADDR);
    end else if (is_regw) begin
      len_ok = (bit_cnt_r == BITS_REGW);
    end else if (is_chip) begin
      len_ok = (bit_cnt_r == BITS_OPCODE);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // block protection check
  logic [NV_WIDTH-1:0] nv_r;
  logic [3:0]          bp;
  logic                area_prot;

  assign bp = nv_r[STS_BP_MSB-2:STS_BP_LSB-2];

  // level selects blocks from the top of the array
  function automatic logic prot_hit(input logic [3:0] lvl, input logic [6:0] blk);
    int cnt;
    cnt = 0;
    if (lvl[3]) begin
      cnt = NUM_BLOCKS;
    end else if (lvl != 4'h0) begin
      cnt = 1 << (int'(lvl) - 1);
    end
    return int'(blk) >= (NUM_BLOCKS - cnt);
  endfunction : prot_hit

  // protected area inhibits program and erase
  always_comb begin
    area_prot = 1'b0;
    if (is_chip) begin
      area_prot = (bp != 4'h0);
    end else if (is_prog || is_erase) begin
      area_prot = prot_hit(bp, addr_r[BLK_MSB:BLK_LSB]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command execution at frame end
  fsg_state_t state_r;
  logic       wel_r;
  logic       busy;
  logic       t_done;
  logic       end_ok;
  logic       status_write_cmd_lock;
  logic       go_start;
  logic       go_reject;
  logic       write_enable_cmd_hit;
  logic       write_disable_cmd_hit;
  logic       pend_status_write_cmd_r;
  logic [5:0] pend_nv_r;

  // busy flag is the machine's state
  assign busy = (state_r == ST_BUSY);
  // frames ending while busy are not executed
  assign end_ok = cs_rise && !busy;
  // lock with protect pin low blocks status write
  assign status_write_cmd_lock = (opcode_r == OP_STATUS_WRITE) && nv_r[STS_LOCK-2] && !wp_n_s;
  assign write_enable_cmd_hit = end_ok && (opcode_r == OP_WRITE_ENABLE) && (bit_cnt_r == BITS_OPCODE);
  assign write_disable_cmd_hit = end_ok && (opcode_r == OP_WRITE_DISABLE) && (bit_cnt_r == BITS_OPCODE);
  // gated command needs the latch set
  assign go_start  = end_ok && is_gated && len_ok && wel_r && !area_prot && !status_write_cmd_lock;
  assign go_reject = end_ok && is_gated && len_ok && !wel_r;

  // state machine: idle until a gated command starts a cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_start) begin
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (t_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  fsg_timer #(.CYCLES(WRITE_CYC)) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (go_start),
    .done    (t_done)
  );

  // write-enable latch; status data never touches it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (write_enable_cmd_hit) begin
      wel_r <= 1'b1;
    end else if (write_disable_cmd_hit || (busy && t_done)) begin
      wel_r <= 1'b0;
    end
  end

  // stage the new non-volatile bits until the cycle ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_status_write_cmd_r <= 1'b0;
      pend_nv_r   <= NV_RESET;
    end else if (go_start) begin
      pend_status_write_cmd_r <= (opcode_r == OP_STATUS_WRITE);
      pend_nv_r   <= wdata_r[7:2];
    end else if (t_done) begin
      pend_status_write_cmd_r <= 1'b0;
    end
  end

  // non-volatile bits, written only by a finished status write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nv_r <= NV_RESET;
    end else if (busy && t_done && pend_status_write_cmd_r) begin
      nv_r <= pend_nv_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status read shifting
  logic [7:0] status_live;
  logic       rd_act_r;
  logic [2:0] rd_idx_r;

  // low two bits come from state and latch only
  assign status_live = {nv_r, wel_r, busy};

  // status byte loops while chip select stays low
  always_ff @(posedge clk_sys) begin
    if (rst || cs_n_s) begin
      rd_act_r <= 1'b0;
      rd_idx_r <= 3'd7;
      so_o     <= 1'b0;
      so_oe_o  <= 1'b0;
    end else begin
      if (sck_rise && bit_cnt_r == BITS_OPCODE - 6'd1) begin
        rd_act_r <= ({shift_r[6:0], si_s} == OP_STATUS_READ);
      end
      if (sck_fall && rd_act_r) begin
        so_o     <= status_live[rd_idx_r];
        so_oe_o  <= 1'b1;
        rd_idx_r <= rd_idx_r - 3'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs toward the array side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_start_o   <= 1'b0;
      op_done_o    <= 1'b0;
      cmd_reject_o <= 1'b0;
      op_code_o    <= 8'h00;
      op_addr_o    <= 24'h00_0000;
    end else begin
      op_start_o   <= go_start;
      op_done_o    <= busy && t_done;
      cmd_reject_o <= go_reject;
      if (go_start) begin
        op_code_o <= opcode_r;
        op_addr_o <= addr_r;
      end
    end
  end

  // quad enable and protection level copies
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_o     <= STATUS_RESET;
      quad_en_o    <= 1'b0;
      prot_level_o <= 4'h0;
    end else begin
      status_o     <= status_live;
      quad_en_o    <= nv_r[STS_QE-2];
      prot_level_o <= bp;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  busy_start_a : assert property (@(posedge clk_sys) disable iff (rst)
    go_start |=> busy ##1 status_o[STS_BUSY])
    else $error("busy not raised after start");

  busy_ro_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(busy) |-> $past(go_start))
    else $error("busy rose without a started cycle");

  start_idle_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(op_start_o) |-> $past(state_r) == ST_IDLE)
    else $error("cycle started while busy");

  start_wel_a : assert property (@(posedge clk_sys) disable iff (rst)
    op_start_o |-> $past(wel_r))
    else $error("cycle started with latch clear");

  wel_set_a : assert property (@(posedge clk_sys) disable iff (rst)
    write_enable_cmd_hit |=> wel_r ##1 status_o[STS_WEL])
    else $error("write enable did not set latch");

  wel_clr_a : assert property (@(posedge clk_sys) disable iff (rst)
    write_disable_cmd_hit |=> !wel_r)
    else $error("write disable did not clear latch");

  wel_done_a : assert property (@(posedge clk_sys) disable iff (rst)
    op_done_o |-> !wel_r && !busy)
    else $error("latch or busy left set after cycle end");

  wel_source_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(wel_r) |-> $past(write_enable_cmd_hit))
    else $error("latch set without write enable");

  nv_write_a : assert property (@(posedge clk_sys) disable iff (rst)
    $changed(nv_r) |-> $past(t_done && pend_status_write_cmd_r))
    else $error("protection bits changed outside status write");

  lock_hold_a : assert property (@(posedge clk_sys) disable iff (rst)
    (end_ok && status_write_cmd_lock) |=> !busy)
    else $error("locked status write started a cycle");

  chip_prot_a : assert property (@(posedge clk_sys) disable iff (rst)
    (go_start && is_chip) |-> bp == 4'h0)
    else $error("chip erase started under protection");

  reject_idle_a : assert property (@(posedge clk_sys) disable iff (rst)
    go_reject |=> cmd_reject_o && !busy)
    else $error("dropped command raised busy");

  cycle_len_c : cover property (@(posedge clk_sys) disable iff (rst)
    op_start_o ##[1:1000] op_done_o);
  status_rd_c : cover property (@(posedge clk_sys) disable iff (rst)
    rd_act_r && sck_fall);
  reject_c : cover property (@(posedge clk_sys) disable iff (rst)
    cmd_reject_o);

endmodule : fsg_gate

// [tb/fsg_host.sv]
// host serial controller model that drives the flash pins
`timescale 1ns/10ps
module fsg_host (
  input  wire logic clk_sys, // system clock
  output logic      sck,     // serial clock, rests low
  output logic      cs_n,    // chip select, active low
  output logic      si,      // serial data to flash
  input  wire logic so       // serial data from flash
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; 8-cycle phases keep the pin filters happy
  task automatic xfer(input logic [63:0] dat, input int nb, output logic [63:0] rx);
    rx = '0;
    tick(1);
    cs_n = 1'b0;
    tick(8);
    for (int i = nb - 1; i >= 0; i--) begin
      si = dat[i];
      tick(8);
      sck = 1'b1;
      rx = {rx[62:0], so};
      tick(8);
      sck = 1'b0;
    end
    tick(8);
    cs_n = 1'b1;
    // released line shows the inverse, never the last bit
    si = ~si;
    tick(8);
  endtask : xfer

  // enable ahead of every gated frame
  task automatic gated(input logic [63:0] dat, input int nb);
    logic [63:0] rx;
    xfer(64'h0000_0000_0000_0006, 8, rx);
    xfer(dat, nb, rx);
  endtask : gated
endmodule : fsg_host

// [tb/tb_fsg_gate.sv]
// self-checking bench for the status byte and write gate
`timescale 1ns/10ps
module tb_fsg_gate;
  import fsg_pkg::*;
  localparam int WCYC = 1000;
  logic        clk_sys, rst, sck, cs_n, si, wp_n, so, so_oe;
  logic        quad_en, op_start, op_done, reject;
  logic [7:0]  status, op_code, cur_op, d;
  logic [3:0]  prot;
  logic [23:0] op_addr, a;
  logic [63:0] rx;
  logic [7:0]  exp_ops[$];
  int          fails, samples_checked, n_rej, cyc, t_start, m_sts, seed;
  logic [7:0]  ops[13] = '{OP_PAGE_PROG, OP_QUAD_PROG_A, OP_QUAD_PROG_B, OP_SECT_ERASE_A,
    OP_SECT_ERASE_B, OP_HALF_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B,
    OP_STATUS_WRITE, OP_FUNC_WRITE, OP_INFO_ERASE, OP_INFO_PROG};
  int          lens[13] = '{40, 40, 40, 32, 32, 32, 32, 8, 8, 16, 16, 32, 40};

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  fsg_gate #(.WRITE_CYC(WCYC)) u_dut (.clk_sys(clk_sys), .rst(rst), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n), .so_o(so), .so_oe_o(so_oe),
    .status_o(status), .quad_en_o(quad_en), .prot_level_o(prot), .op_start_o(op_start),
    .op_code_o(op_code), .op_addr_o(op_addr), .op_done_o(op_done), .cmd_reject_o(reject));
  fsg_host u_host (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [63:0] fr(logic [7:0] op, int nb, logic [31:0] pl);
    return (64'(op) << (nb - 8)) | 64'(pl);
  endfunction : fr

  ////////////////////////////////////////////////////////////////////////////
  // model of starts: every start must be one the model expects
  // sampled mid-cycle so registered pulses are settled, never raced at the edge
  always @(negedge clk_sys) begin
    cyc++;
    if (op_start === 1'b1) begin
      t_start = cyc;
      chk(64'(exp_ops.size() > 0), 64'd1);
      if (exp_ops.size() > 0) cur_op = exp_ops.pop_front();
    end
    if (op_done === 1'b1) begin
      // the timer's done pulse comes as its count reaches zero; op_done_o is registered one cycle later
      chk(64'(cyc - t_start), 64'(WCYC + 1));
      chk(64'(op_code), 64'(cur_op));
    end
    if (reject === 1'b1) n_rej++;
  end

  // bounded wait for the busy flag to drop
  task automatic settle;
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < 2000 && status[0] !== 1'b0; i++) @(posedge clk_sys);
    #1;
    chk(64'(status[0]), 64'd0);
  endtask : settle

  // read two repeats of the status byte
  task automatic rd_chk;
    u_host.xfer(fr(OP_STATUS_READ, 24, 0), 24, rx);
    chk(rx[15:0], {2{m_sts[7:0]}});
    chk(64'(status), 64'(m_sts[7:0]));
    chk(64'(so_oe), 64'd0);
  endtask : rd_chk

  // one gated frame; en sends write enable first, go expects a start
  task automatic run(input logic [7:0] op, input int nb, input logic [31:0] pl,
                     input bit en, input bit go);
    int r0;
    bit rj;
    r0 = n_rej;
    rj = !en && (m_sts & 2) == 0;
    if (go) exp_ops.push_back(op);
    if (en) m_sts = m_sts | 2;
    if (en) u_host.gated(fr(op, nb, pl), nb);
    else u_host.xfer(fr(op, nb, pl), nb, rx);
    settle();
    chk(64'(n_rej - r0), 64'(rj));
    if (go) m_sts = (op == OP_STATUS_WRITE) ? (pl & 8'hFC) : (m_sts & 8'hFD);
    rd_chk();
  endtask : run

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    // the full run needs roughly 57k cycles
    #(10 * 95000);
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    m_sts = 0;
    seed = $urandom(32'h9333);
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    rd_chk();
    foreach (ops[i]) run(ops[i], lens[i], 0, 0, 0);
    foreach (ops[i]) run(ops[i], lens[i], 0, 1, 1);
    m_sts = 2;
    u_host.xfer(fr(OP_WRITE_ENABLE, 8, 0), 8, rx);
    rd_chk();
    m_sts = 0;
    u_host.xfer(fr(OP_WRITE_DISABLE, 8, 0), 8, rx);
    rd_chk();
    run(OP_CHIP_ERASE_A, 8, 0, 0, 0);
    d = 8'($urandom) & 8'h7F;
    run(OP_STATUS_WRITE, 16, d, 1, 1);
    chk(64'(quad_en), 64'(d[6]));
    chk(64'(prot), 64'(d[5:2]));
    run(OP_STATUS_WRITE, 16, 8'h04, 1, 1);
    run(OP_BLOCK_ERASE, 32, 24'h7F_0000, 1, 0);
    run(OP_CHIP_ERASE_A, 8, 0, 1, 0);
    a = 24'($urandom % 32'h007F_0000);
    run(OP_SECT_ERASE_B, 32, a, 1, 1);
    chk(64'(op_addr), 64'(a));
    run(OP_PAGE_PROG, 40, {a, 8'hA5}, 1, 1);
    run(OP_STATUS_WRITE, 16, 8'h80, 1, 1);
    wp_n = 1'b0;
    run(OP_STATUS_WRITE, 16, 8'h00, 1, 0);
    wp_n = 1'b1;
    run(OP_STATUS_WRITE, 16, 8'h00, 1, 1);
    // a chip erase sent while the status write is busy must be dropped without a trace
    exp_ops.push_back(OP_STATUS_WRITE);
    u_host.gated(fr(OP_STATUS_WRITE, 16, 32'h3F), 16);
    repeat (12) @(posedge clk_sys);
    #1;
    chk(64'(status[0]), 64'd1);
    m_sts = 3;
    u_host.gated(fr(OP_CHIP_ERASE_B, 8, 0), 8);
    rd_chk();
    settle();
    m_sts = 8'h3C;
    rd_chk();
    chk(64'(exp_ops.size()), 64'd0);
    tally_and_finish();
  end
endmodule : tb_fsg_gate
